// file: trace_fmt_map.vh
// Constants for the trace formatter output stage: identifiers, fixed bytes,
// mode codes and frame geometry.
// Assumes it is included by bare name from the formatter design file.
`ifndef TRACE_FMT_MAP_VH
`define TRACE_FMT_MAP_VH

// ----------------------------------------------------------------------------
// Identifiers and fixed bytes
// ----------------------------------------------------------------------------
`define FMT_ID_NULL        7'h00
`define FMT_ID_FLUSH       7'h7B
`define FMT_ID_TRIG        7'h7D
`define FMT_FLUSH_ALL      8'h00
`define FMT_TRIG_UNKNOWN   8'h00
`define FMT_NULL_DATA      8'h00
`define FMT_SYNC_LO        8'hFF
`define FMT_SYNC_HI        8'h7F
`define FMT_TERM_MARK      8'h01
`define FMT_TERM_ZERO      8'h00

// ----------------------------------------------------------------------------
// Modes and frame geometry
// ----------------------------------------------------------------------------
`define FMT_MODE_BYPASS    2'h0
`define FMT_MODE_NORMAL    2'h1
`define FMT_MODE_CONT      2'h2
`define FMT_LAST_SLOT      4'hE
`define FMT_AUX_SLOT       4'hF
`define FMT_REPEAT_FRAMES  10
`define FMT_PORT_BYTES     4

`endif

// file: trace_formatter.v
// Trace formatter output stage: frames tagged source bytes into 16-byte
// frames, or passes them through in bypass, and drives a byte-wide port.
// Assumes sources and flush/trigger requests come from logic on i_clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "trace_fmt_map.vh"

module trace_formatter #(
	parameter HAS_BYPASS    = 1,
	parameter HAS_CONT      = 1,
	parameter REPEAT_FRAMES = `FMT_REPEAT_FRAMES,
	parameter PORT_BYTES    = `FMT_PORT_BYTES
) (
	// Clock, reset, enable
	input  wire       i_clk_sys,
	input  wire       i_rstn,
	input  wire       i_ce,
	// Configuration
	input  wire [1:0] i_mode,
	input  wire       i_src_id_toggle,
	// Trace source
	input  wire       i_src_valid,
	input  wire [7:0] i_src_data,
	input  wire [6:0] i_src_id,
	output wire       o_src_ready,
	// Events
	input  wire       i_trigger,
	input  wire       i_flush_req,
	output reg        o_flush_done,
	// Trace port
	output reg  [7:0] o_port_data,
	output reg        o_port_valid,
	output reg        o_trace_control_pin
);

	// ------------------------------------------------------------------------
	// States and item kinds
	// ------------------------------------------------------------------------
	localparam S_BUILD = 2'h0;
	localparam S_EMIT  = 2'h1;
	localparam S_BYP   = 2'h2;
	localparam S_BTERM = 2'h3;
	localparam K_SRC   = 2'h0;
	localparam K_TRIG  = 2'h1;
	localparam K_RESP  = 2'h2;
	localparam K_PAD   = 2'h3;

	reg  [1:0] state_r;
	reg  [1:0] mode_r;
	reg  [3:0] slot_r;
	reg  [3:0] eidx_r;
	reg  [7:0] fb_r [0:14];
	reg  [7:0] aux_r;
	reg  [7:0] hold_r;
	reg        hold_v_r;
	reg  [6:0] cur_id_r;
	reg        rep_r;
	reg  [7:0] fc_r;
	reg        trig_pend_r;
	reg        flush_pend_r;
	reg        pad_r;
	reg        ob_r;
	reg  [7:0] bc_r;
	reg        bfirst_r;
	reg        zw_r;

	// Mode allowed by build options and source behaviour
	wire [1:0] mode_ok = (i_mode == `FMT_MODE_BYPASS && HAS_BYPASS != 0 && !i_src_id_toggle) ?
		`FMT_MODE_BYPASS : (i_mode == `FMT_MODE_CONT && HAS_CONT != 0) ?
		`FMT_MODE_CONT : `FMT_MODE_NORMAL;

	// Next item to place in a frame, by priority
	reg        it_v;
	reg  [1:0] it_k;
	reg  [6:0] it_id;
	reg  [7:0] it_d;
	always @* begin
		it_v  = 1'b1;
		it_k  = K_SRC;
		it_id = i_src_id;
		it_d  = i_src_data;
		if (trig_pend_r && mode_r == `FMT_MODE_CONT) begin
			it_k  = K_TRIG;
			it_id = `FMT_ID_TRIG;
			it_d  = `FMT_TRIG_UNKNOWN;
		end else if (i_src_valid) begin
			it_k  = K_SRC;
		end else if (flush_pend_r) begin
			it_k  = K_RESP;
			it_id = `FMT_ID_FLUSH;
			it_d  = `FMT_FLUSH_ALL;
		end else if (pad_r) begin
			it_k  = K_PAD;
			it_id = `FMT_ID_NULL;
			it_d  = `FMT_NULL_DATA;
		end else begin
			it_v  = 1'b0;
		end
	end

	// Placement decisions
	wire chg     = rep_r || (it_id != cur_id_r);
	wire place   = (state_r == S_BUILD) && it_v;
	wire consume = place && ((slot_r == `FMT_LAST_SLOT || hold_v_r) ? !chg : 1'b1);
	wire byp_tx  = (state_r == S_BYP) && i_src_valid;
	wire idle    = ((state_r == S_BUILD) && slot_r == 4'h0 && !hold_v_r && !it_v) ||
		((state_r == S_BYP) && !i_src_valid && !flush_pend_r);
	wire [2:0] pair = slot_r[3:1];

	// Source handshake, combinational
	assign o_src_ready = i_ce && ((consume && it_k == K_SRC) || byp_tx);

	// ------------------------------------------------------------------------
	// Main sequencer
	// ------------------------------------------------------------------------
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r             <= S_BUILD;
			mode_r              <= `FMT_MODE_NORMAL;
			slot_r              <= 4'h0;
			eidx_r              <= 4'h0;
			aux_r               <= 8'h00;
			hold_r              <= 8'h00;
			hold_v_r            <= 1'b0;
			cur_id_r            <= `FMT_ID_NULL;
			rep_r               <= 1'b0;
			fc_r                <= 8'h00;
			trig_pend_r         <= 1'b0;
			flush_pend_r        <= 1'b0;
			pad_r               <= 1'b0;
			ob_r                <= 1'b0;
			bc_r                <= 8'h00;
			bfirst_r            <= 1'b1;
			zw_r                <= 1'b0;
			o_flush_done        <= 1'b0;
			o_port_data         <= 8'h00;
			o_port_valid        <= 1'b0;
			o_trace_control_pin <= 1'b1;
		end else if (i_ce) begin
			o_flush_done <= 1'b0;
			// Mode taken only between frames
			if (idle) begin
				mode_r  <= mode_ok;
				state_r <= (mode_ok == `FMT_MODE_BYPASS) ? S_BYP : S_BUILD;
			end
			case (state_r)
			S_BUILD: begin
				// Idle port: halfword sync in continuous, control pin otherwise
				o_port_data         <= ob_r ? `FMT_SYNC_HI : `FMT_SYNC_LO;
				o_port_valid        <= (mode_r == `FMT_MODE_CONT);
				o_trace_control_pin <= (mode_r != `FMT_MODE_CONT);
				if (mode_r == `FMT_MODE_CONT)
					ob_r <= ~ob_r;
				if (place) begin
					if (slot_r == `FMT_LAST_SLOT) begin
						if (chg) begin
							fb_r[14] <= {it_id, 1'b1};
							aux_r[7] <= 1'b0;
							cur_id_r <= it_id;
							rep_r    <= 1'b0;
							fc_r     <= 8'h00;
						end else begin
							fb_r[14] <= {it_d[7:1], 1'b0};
							aux_r[7] <= it_d[0];
						end
						state_r <= S_EMIT;
						eidx_r  <= 4'h0;
					end else if (!hold_v_r) begin
						if (chg) begin
							// Identifier now, data in the odd slot
							fb_r[slot_r]          <= {it_id, 1'b1};
							aux_r[pair]           <= 1'b0;
							fb_r[slot_r + 4'h1]   <= it_d;
							cur_id_r              <= it_id;
							rep_r                 <= 1'b0;
							fc_r                  <= 8'h00;
							slot_r                <= slot_r + 4'h2;
						end else begin
							hold_r   <= it_d;
							hold_v_r <= 1'b1;
						end
					end else if (!chg) begin
						fb_r[slot_r]        <= {hold_r[7:1], 1'b0};
						aux_r[pair]         <= hold_r[0];
						fb_r[slot_r + 4'h1] <= it_d;
						slot_r              <= slot_r + 4'h2;
						hold_v_r            <= 1'b0;
					end else begin
						// New identifier takes effect after the held byte
						fb_r[slot_r]        <= {it_id, 1'b1};
						aux_r[pair]         <= 1'b1;
						fb_r[slot_r + 4'h1] <= hold_r;
						cur_id_r            <= it_id;
						rep_r               <= 1'b0;
						fc_r                <= 8'h00;
						slot_r              <= slot_r + 4'h2;
						hold_v_r            <= 1'b0;
					end
					if (consume && it_k == K_TRIG)
						trig_pend_r <= 1'b0;
					if (consume && it_k == K_RESP) begin
						flush_pend_r <= 1'b0;
						pad_r        <= 1'b1;
					end
				end
			end
			S_EMIT: begin
				if (mode_r == `FMT_MODE_CONT && ob_r) begin
					// Finish a half-sent sync to keep 16-bit alignment
					o_port_data         <= `FMT_SYNC_HI;
					o_port_valid        <= 1'b1;
					o_trace_control_pin <= 1'b0;
					ob_r                <= 1'b0;
				end else begin
					o_port_data  <= (eidx_r == `FMT_AUX_SLOT) ? aux_r : fb_r[eidx_r];
					o_port_valid <= 1'b1;
					// Trigger marked on the control pin in normal mode
					o_trace_control_pin <= (mode_r == `FMT_MODE_NORMAL) && trig_pend_r;
					if (mode_r == `FMT_MODE_NORMAL)
						trig_pend_r <= 1'b0;
					eidx_r <= eidx_r + 4'h1;
					if (eidx_r == `FMT_AUX_SLOT) begin
						state_r <= S_BUILD;
						slot_r  <= 4'h0;
						fc_r    <= fc_r + 8'h01;
						if (fc_r == REPEAT_FRAMES - 1)
							rep_r <= 1'b1;
						if (pad_r) begin
							pad_r        <= 1'b0;
							o_flush_done <= 1'b1;
						end
					end
				end
			end
			S_BYP: begin
				// Unchanged bytes, control pin marks idle and trigger
				o_port_data         <= i_src_data;
				o_port_valid        <= i_src_valid;
				o_trace_control_pin <= !i_src_valid || trig_pend_r;
				if (i_src_valid) begin
					trig_pend_r <= 1'b0;
					bc_r        <= (bc_r == PORT_BYTES - 1) ? 8'h00 : bc_r + 8'h01;
				end else if (flush_pend_r) begin
					state_r  <= S_BTERM;
					bfirst_r <= 1'b1;
					zw_r     <= 1'b0;
				end
			end
			default: begin
				// One set bit, zeros to the port word, then one zero word
				o_port_data         <= bfirst_r ? `FMT_TERM_MARK : `FMT_TERM_ZERO;
				o_port_valid        <= 1'b1;
				o_trace_control_pin <= 1'b0;
				bfirst_r            <= 1'b0;
				bc_r <= (bc_r == PORT_BYTES - 1) ? 8'h00 : bc_r + 8'h01;
				if (bc_r == PORT_BYTES - 1) begin
					zw_r <= 1'b1;
					if (zw_r) begin
						state_r      <= S_BYP;
						flush_pend_r <= 1'b0;
						o_flush_done <= 1'b1;
					end
				end
			end
			endcase
			// Requests win over a same-cycle clear
			if (i_trigger)
				trig_pend_r <= 1'b1;
			if (i_flush_req)
				flush_pend_r <= 1'b1;
		end
	end

endmodule
`default_nettype wire

// file: trace_capture_model.sv
// Capture model of the analyzer: records each byte the port marks valid.
// Assumes it shares the formatter clock; it drives nothing back.
`timescale 1ns/10ps
`default_nettype none
module trace_capture_model (
	// Port side
	input wire logic       i_clk_sys,
	input wire logic       i_port_valid,
	input wire logic [7:0] i_port_data,
	input wire logic       i_ctl
);
	logic [8:0] cap_q[$];
	// Keep control mark with its byte; stripping is left to the judge
	always @(posedge i_clk_sys) begin
		if (i_port_valid) cap_q.push_back({i_ctl, i_port_data});
	end
endmodule
`default_nettype wire

// file: trace_fmt_props.sv
// Checker for the formatter port: flush, trigger and enable timing.
// Assumes it is bound to the formatter top with matching port names.
`timescale 1ns/10ps
`default_nettype none
module trace_fmt_props (
	input wire logic       i_clk_sys,
	input wire logic       i_rstn,
	input wire logic       i_ce,
	input wire logic       i_trigger,
	input wire logic       i_flush_req,
	input wire logic       o_src_ready,
	input wire logic       o_flush_done,
	input wire logic [7:0] o_port_data,
	input wire logic       o_port_valid,
	input wire logic       o_trace_control_pin
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	logic flush_pend_r;
	logic trig_pend_r;
	// Requests remembered until answered at an enabled edge
	always @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			flush_pend_r <= 1'b0;
			trig_pend_r  <= 1'b0;
		end else begin
			flush_pend_r <= i_flush_req | (flush_pend_r & ~(o_flush_done & i_ce));
			trig_pend_r  <= i_trigger | (trig_pend_r & ~(o_port_valid & o_trace_control_pin & i_ce));
		end
	end
	sequence s_flush_ends;
		##[1:300] o_flush_done;
	endsequence
	AST_FLUSH_BOUNDED: assert property (i_flush_req |-> s_flush_ends)
		else $error("flush sequence did not finish");
	AST_FLUSH_PULSE: assert property (o_flush_done && i_ce |=> !o_flush_done)
		else $error("flush done longer than one cycle");
	AST_FLUSH_CAUSE: assert property (o_flush_done |-> flush_pend_r)
		else $error("flush done without a request");
	AST_FLUSH_ON_BYTE: assert property (o_flush_done |-> o_port_valid)
		else $error("flush done without a port byte");
	AST_IDLE_CTL: assert property (!o_port_valid |-> o_trace_control_pin)
		else $error("idle port without control mark");
	AST_TRIG_CAUSE: assert property (o_port_valid && o_trace_control_pin |-> trig_pend_r)
		else $error("trigger mark without trigger");
	AST_CE_READY: assert property (!i_ce |-> !o_src_ready)
		else $error("ready while disabled");
	AST_CE_FREEZE: assert property (!i_ce |=> $stable(o_port_data) && $stable(o_port_valid))
		else $error("port moved while disabled");
endmodule
`default_nettype wire

// file: trace_formatter_tb.sv
// Testbench: bypass flush, framed run with flush, continuous idle.
// Assumes the capture model and checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "trace_fmt_map.vh"
module trace_formatter_tb;
	logic       clk = 1'b0, rstn = 1'b0, ce = 1'b1, tog = 1'b0;
	logic       src_valid = 1'b0, trig = 1'b0, flush = 1'b0;
	logic [1:0] mode = `FMT_MODE_NORMAL;
	logic [7:0] src_data = 8'h00;
	logic [6:0] src_id = 7'h00;
	wire        src_ready, done, pvalid, ctl;
	wire  [7:0] pdata;
	int         errors = 0, tests_run = 0;
	always #10 clk = ~clk;
	trace_formatter dut_u (.i_clk_sys(clk), .i_rstn(rstn), .i_ce(ce), .i_mode(mode),
		.i_src_id_toggle(tog), .i_src_valid(src_valid), .i_src_data(src_data),
		.i_src_id(src_id), .o_src_ready(src_ready), .i_trigger(trig), .i_flush_req(flush),
		.o_flush_done(done), .o_port_data(pdata), .o_port_valid(pvalid),
		.o_trace_control_pin(ctl));
	trace_capture_model cap_u (.i_clk_sys(clk), .i_port_valid(pvalid), .i_port_data(pdata),
		.i_ctl(ctl));
	task automatic final_report;
		if (errors == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic set_mode(input logic [1:0] m, input logic t);
		mode = m;
		tog = t;
		repeat (4) tick();
		cap_u.cap_q.delete();
	endtask
	task automatic send(input logic [7:0] d, input logic [6:0] id);
		int n;
		n = 0;
		src_valid = 1'b1;
		src_data = d;
		src_id = id;
		#1;
		while (src_ready !== 1'b1 && n < 200) begin
			tick();
			n++;
		end
		if (n == 200) begin
			errors++;
			final_report();
		end
		tick();
	endtask
	task automatic do_flush;
		int n;
		n = 0;
		src_valid = 1'b0;
		flush = 1'b1;
		tick();
		flush = 1'b0;
		while (done !== 1'b1 && n < 300) begin
			tick();
			n++;
		end
		if (n == 300) begin
			errors++;
			final_report();
		end
		repeat (40) tick();
	endtask
	// Bypass: trigger mark, unchanged bytes, end pattern to a word boundary
	task automatic t_bypass;
		logic [7:0] exp[8] = '{8'hAA, 8'h55, 8'hAA, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
		set_mode(`FMT_MODE_BYPASS, 1'b0);
		trig = 1'b1;
		tick();
		trig = 1'b0;
		send(8'hAA, 7'h05);
		send(8'h55, 7'h05);
		send(8'hAA, 7'h05);
		do_flush();
		check(9'(cap_u.cap_q.size()), 9'h008);
		for (int i = 0; i < 8; i++) check(cap_u.cap_q[i], {i == 0, exp[i]});
	endtask
	// Toggling source asks bypass but gets frames; long run, then flush
	task automatic t_frame;
		int ids = 0, nul = 0, ff = 0, k = -1;
		int mk = 0, cid = 0, resp = -1;
		logic [7:0] b;
		logic [7:0] a;
		set_mode(`FMT_MODE_BYPASS, 1'b1);
		// Trigger while idle: marked on the first emitted frame byte
		trig = 1'b1;
		tick();
		trig = 1'b0;
		ce = 1'b0;
		src_valid = 1'b1;
		tick();
		check({8'h00, src_ready}, 9'h000);
		ce = 1'b1;
		for (int i = 0; i < 200; i++) send(8'h20, 7'h05);
		do_flush();
		check(cap_u.cap_q[0], 9'h10B);
		check(9'(cap_u.cap_q.size() % 16), 9'h000);
		for (int i = 0; i < cap_u.cap_q.size(); i++) begin
			b = cap_u.cap_q[i][7:0];
			mk += cap_u.cap_q[i][8];
			ff += (b == 8'hFF);
			if (i % 2 == 0) begin
				ids += (b == 8'h0B);
				nul += (b == 8'h01);
				if (b == 8'hF7 && k < 0) k = i;
			end
		end
		check(9'(ids > 1), 9'h001);
		check(9'(nul > 0), 9'h001);
		check(9'(ff), 9'h000);
		check(9'(k >= 0), 9'h001);
		check(9'(mk), 9'h001);
		// Decode frames: an identifier with its aux bit set switches after the next byte
		for (int f = 0; f + 15 < cap_u.cap_q.size(); f += 16) begin
			a = cap_u.cap_q[f + 15][7:0];
			for (int s = 0; s < 15; s += 2) begin
				b = cap_u.cap_q[f + s][7:0];
				if (b[0] && !a[s / 2]) cid = b[7:1];
				if (!b[0] && cid == `FMT_ID_FLUSH && resp < 0) resp = {b[7:1], a[s / 2]};
				if (s < 14 && cid == `FMT_ID_FLUSH && resp < 0) resp = cap_u.cap_q[f + s + 1][7:0];
				if (b[0] && a[s / 2]) cid = b[7:1];
			end
		end
		check(9'(resp), {1'b0, `FMT_FLUSH_ALL});
	endtask
	// Continuous idle: halfword sync, low byte first, no control mark
	task automatic t_cont;
		int n = 0, k = -1, j = -1;
		set_mode(`FMT_MODE_CONT, 1'b0);
		while (pdata !== 8'hFF && n < 8) begin
			tick();
			n++;
		end
		check({ctl, pdata}, 9'h0FF);
		tick();
		check({ctl, pdata}, 9'h07F);
		check({8'h00, pvalid}, 9'h001);
		// Trigger and two sources framed in continuous mode, then flushed
		trig = 1'b1;
		tick();
		trig = 1'b0;
		send(8'h42, 7'h05);
		send(8'h43, 7'h06);
		do_flush();
		for (int i = 0; i < cap_u.cap_q.size(); i++) begin
			if (cap_u.cap_q[i] == {1'b0, `FMT_ID_TRIG, 1'b1} && k < 0) k = i;
			if (cap_u.cap_q[i] == 9'h00D && j < 0) j = i;
		end
		check(k >= 0 ? cap_u.cap_q[k + 1] : 9'h1FF, {1'b0, `FMT_TRIG_UNKNOWN});
		check(9'(k >= 0 && j > k), 9'h001);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1;
		rstn = 1'b1;
		t_bypass();
		t_frame();
		t_cont();
		final_report();
	end
endmodule
bind trace_formatter trace_fmt_props props_u (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
	.i_ce(i_ce), .i_trigger(i_trigger), .i_flush_req(i_flush_req), .o_src_ready(o_src_ready),
	.o_flush_done(o_flush_done), .o_port_data(o_port_data), .o_port_valid(o_port_valid),
	.o_trace_control_pin(o_trace_control_pin));
`default_nettype wire
